// ==== hw/frtc_pkg.sv ====
package frtc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] FRTC_ADDR_SECOND_TRANSMIT_LIMIT = 8'h0a;
  localparam logic [7:0] FRTC_ADDR_FLASH_RAMP_RATES = 8'h0b;
  localparam logic [7:0] FRTC_ADDR_TORCH_RAMP_RATES = 8'h0c;
  localparam logic [7:0] FRTC_ADDR_FLASH_SAFETY_TIMER = 8'h0d;

  // ==========================================================
  // Reset values
  localparam logic [7:0] FRTC_RESET_SECOND_TRANSMIT_LIMIT = 8'hc0;
  localparam logic [7:0] FRTC_RESET_RAMP_RATES = 8'h00;
  localparam logic [7:0] FRTC_RESET_FLASH_SAFETY_TIMER = 8'h00;
  localparam logic [7:0] FRTC_UNMAPPED_READ = 8'h00;

  // ==========================================================
  // Field positions
  localparam int FRTC_LIMIT_ENABLE_BIT = 7;
  localparam int FRTC_PULLDOWN_BIT = 6;
  localparam int FRTC_CAP_MSB = 5;
  localparam int FRTC_RISE_MSB = 6;
  localparam int FRTC_RISE_LSB = 4;
  localparam int FRTC_FALL_MSB = 2;
  localparam int FRTC_FALL_LSB = 0;
  localparam logic [7:0] FRTC_RAMP_WRITABLE_MASK = 8'h77;
  localparam int FRTC_TIMER_MODE_BIT = 7;
  localparam int FRTC_TIMER_CODE_MSB = 6;

  // ==========================================================
  // Timing
  localparam int FRTC_CLOCK_PERIOD_NS = 20;
  localparam int FRTC_COUNT_WIDTH = 27;
  localparam int FRTC_CHANNELS = 2;
  localparam int FRTC_CH_FLASH = 0;
  localparam int FRTC_CH_TORCH = 1;

  // Flash ramp times in nanoseconds, code 0 first.
  localparam int FRTC_FLASH_RAMP_NS [8] = '{384000, 640000, 1152000, 2176000,
                                            4224000, 8320000, 16512000, 32896000};
  // Torch ramp times in nanoseconds, code 0 first.
  localparam int FRTC_TORCH_RAMP_NS [8] = '{16392000, 32776000, 65544000, 131080000,
                                            262152000, 524296000, 1048000000, 2097000000};

  // Flash timer segments: last code of each segment, its time and step, in nanoseconds.
  localparam int FRTC_TMR_BASE_NS = 128000;
  localparam int FRTC_TMR_STEP0_NS = 256000;
  localparam int FRTC_TMR_END0_NS = 896000;
  localparam int FRTC_TMR_STEP1_NS = 512000;
  localparam int FRTC_TMR_END1_NS = 2944000;
  localparam int FRTC_TMR_STEP2_NS = 1024000;
  localparam int FRTC_TMR_END2_NS = 11136000;
  localparam int FRTC_TMR_STEP3_NS = 2048000;
  localparam int FRTC_TMR_END3_NS = 43904000;
  localparam int FRTC_TMR_STEP4_NS = 4096000;
  localparam int FRTC_TMR_END4_NS = 174976000;
  localparam int FRTC_TMR_STEP5_NS = 8192000;

  typedef enum logic [1:0] {
    FRTC_RAMP_IDLE = 2'b00,
    FRTC_RAMP_RISE = 2'b01,
    FRTC_RAMP_HOLD = 2'b10,
    FRTC_RAMP_FALL = 2'b11
  } frtc_ramp_state_t;

  // Converts a time to clock cycles, rounded down, never below one cycle.
  function automatic logic [FRTC_COUNT_WIDTH-1:0] frtc_cycles(input int ns, input int period_ns);
    int c;
    c = ns / period_ns;
    if (c < 1) begin
      c = 1;
    end
    return c[FRTC_COUNT_WIDTH-1:0];
  endfunction

  // Flash timer duration in nanoseconds for a seven-bit code.
  function automatic int frtc_timer_ns(input logic [6:0] code);
    int c;
    int ns;
    c = int'(code);
    if (c < 4) begin
      ns = FRTC_TMR_BASE_NS + FRTC_TMR_STEP0_NS * c;
    end else if (c < 8) begin
      ns = FRTC_TMR_END0_NS + FRTC_TMR_STEP1_NS * (c - 3);
    end else if (c < 16) begin
      ns = FRTC_TMR_END1_NS + FRTC_TMR_STEP2_NS * (c - 7);
    end else if (c < 32) begin
      ns = FRTC_TMR_END2_NS + FRTC_TMR_STEP3_NS * (c - 15);
    end else if (c < 64) begin
      ns = FRTC_TMR_END3_NS + FRTC_TMR_STEP4_NS * (c - 31);
    end else begin
      ns = FRTC_TMR_END4_NS + FRTC_TMR_STEP5_NS * (c - 63);
    end
    return ns;
  endfunction

endpackage

// ==== hw/frtc_flash_timer.sv ====
`timescale 1ns/1ps
module frtc_flash_timer import frtc_pkg::*; #(
  parameter int CLOCK_PERIOD_NS = FRTC_CLOCK_PERIOD_NS
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_clear,
  input wire logic i_max_mode,
  input wire logic [6:0] i_duration_code,
  input wire logic i_trigger,
  output logic o_flash_enable
);

  typedef struct packed {
    logic running;
    logic expired;
    logic trigger_prev;
    logic [FRTC_COUNT_WIDTH-1:0] count;
  } frtc_timer_state_t;

  frtc_timer_state_t state_reg;
  frtc_timer_state_t state_next;

  // ==========================================================
  // Safety timer
  always_comb begin
    logic [FRTC_COUNT_WIDTH-1:0] load;
    load = frtc_cycles(frtc_timer_ns(i_duration_code), CLOCK_PERIOD_NS);
    state_next = state_reg;
    state_next.trigger_prev = i_trigger;
    if (i_clear) begin
      state_next = '0;
    end else if (!i_max_mode) begin
      state_next.expired = 1'b0;
      if (state_reg.running) begin
        if (state_reg.count <= 1) begin
          state_next.running = 1'b0;
        end else begin
          state_next.count = state_reg.count - 1'b1;
        end
      end else if (i_trigger && !state_reg.trigger_prev) begin
        state_next.running = 1'b1;
        state_next.count = load;
      end
    end else begin
      if (!i_trigger) begin
        state_next.running = 1'b0;
        state_next.expired = 1'b0;
      end else if (state_reg.running) begin
        if (state_reg.count <= 1) begin
          state_next.running = 1'b0;
          state_next.expired = 1'b1;
        end else begin
          state_next.count = state_reg.count - 1'b1;
        end
      end else if (!state_reg.expired) begin
        state_next.running = 1'b1;
        state_next.count = load;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_flash_enable = state_reg.running;

endmodule

// ==== hw/frtc_top.sv ====
`timescale 1ns/1ps
// Operation
// - Bit 7 of the transmit-limit register turns the second transmit-event current cap on or off.
// - Bit 6 of the transmit-limit register turns the second transmit input pulldown on or off.
// - During a second transmit event the flash current code is capped at the six-bit cap code.
// - All four registers return to defaults on logic supply undervoltage, 0xc0 and 0x00.
// - Flash rise time select in bits 6:4 picks one of eight ramp-up times from 384 us to 32.896 ms.
// - Flash fall time select in bits 2:0 uses the same eight-entry table for ramp-down.
// - Torch rise time select in bits 6:4 picks one of eight ramp-up times from 16.392 ms to 2.097 s.
// - Torch fall time select in bits 2:0 uses the same eight-entry table for ramp-down.
// - Bit 7 of the flash timer register selects one-shot mode at 0 or maximum mode at 1.
// - The seven-bit flash timer duration maps 0.128 ms to 699.26 ms with widening steps.
module frtc_top import frtc_pkg::*; #(
  parameter int CLOCK_PERIOD_NS = FRTC_CLOCK_PERIOD_NS
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_logic_supply_undervoltage,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic i_second_transmit_event_input,
  input wire logic [5:0] i_flash_current_request,
  input wire logic i_flash_trigger,
  input wire logic i_torch_request,
  output logic [7:0] o_reg_rdata,
  output logic o_second_tx_input_pulldown,
  output logic [5:0] o_flash_current_code,
  output logic o_flash_enable,
  output logic [1:0] o_flash_ramp_phase,
  output logic [1:0] o_torch_ramp_phase
);

  typedef struct packed {
    logic [7:0] second_transmit_limit_reg;
    logic [7:0] flash_ramp_rates_reg;
    logic [7:0] torch_ramp_rates_reg;
    logic [7:0] flash_safety_timer_reg;
    logic [7:0] rdata;
    logic [5:0] current_code;
    frtc_ramp_state_t [FRTC_CHANNELS-1:0] phase;
    logic [FRTC_CHANNELS-1:0][FRTC_COUNT_WIDTH-1:0] count;
  } frtc_state_t;

  localparam frtc_state_t FRTC_STATE_RESET = '{
    second_transmit_limit_reg: FRTC_RESET_SECOND_TRANSMIT_LIMIT,
    flash_ramp_rates_reg: FRTC_RESET_RAMP_RATES,
    torch_ramp_rates_reg: FRTC_RESET_RAMP_RATES,
    flash_safety_timer_reg: FRTC_RESET_FLASH_SAFETY_TIMER,
    rdata: FRTC_UNMAPPED_READ,
    current_code: '0,
    phase: '{default: FRTC_RAMP_IDLE},
    count: '0
  };

  frtc_state_t state_reg;
  frtc_state_t state_next;
  logic flash_timer_enable;

  // ==========================================================
  // Flash safety timer
  frtc_flash_timer #(
    .CLOCK_PERIOD_NS(CLOCK_PERIOD_NS)
  ) i_frtc_flash_timer (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_clear(i_logic_supply_undervoltage),
    .i_max_mode(state_reg.flash_safety_timer_reg[FRTC_TIMER_MODE_BIT]),
    .i_duration_code(state_reg.flash_safety_timer_reg[FRTC_TIMER_CODE_MSB:0]),
    .i_trigger(i_flash_trigger),
    .o_flash_enable(flash_timer_enable)
  );

  // ==========================================================
  // Transmit-limit fields
  logic second_tx_limit_enable;
  logic second_tx_input_pulldown;
  logic [5:0] second_tx_flash_current_cap;

  assign second_tx_limit_enable = state_reg.second_transmit_limit_reg[FRTC_LIMIT_ENABLE_BIT];
  assign second_tx_input_pulldown = state_reg.second_transmit_limit_reg[FRTC_PULLDOWN_BIT];
  assign second_tx_flash_current_cap = state_reg.second_transmit_limit_reg[FRTC_CAP_MSB:0];

  // ==========================================================
  // Ramp durations per channel
  logic [FRTC_CHANNELS-1:0][2:0] rise_code;
  logic [FRTC_CHANNELS-1:0][2:0] fall_code;
  logic [FRTC_CHANNELS-1:0][FRTC_COUNT_WIDTH-1:0] rise_cycles;
  logic [FRTC_CHANNELS-1:0][FRTC_COUNT_WIDTH-1:0] fall_cycles;

  assign rise_code[FRTC_CH_FLASH] = state_reg.flash_ramp_rates_reg[FRTC_RISE_MSB:FRTC_RISE_LSB];
  assign fall_code[FRTC_CH_FLASH] = state_reg.flash_ramp_rates_reg[FRTC_FALL_MSB:FRTC_FALL_LSB];
  assign rise_code[FRTC_CH_TORCH] = state_reg.torch_ramp_rates_reg[FRTC_RISE_MSB:FRTC_RISE_LSB];
  assign fall_code[FRTC_CH_TORCH] = state_reg.torch_ramp_rates_reg[FRTC_FALL_MSB:FRTC_FALL_LSB];

  for (genvar ch = 0; ch < FRTC_CHANNELS; ch++) begin : g_ramp_time
    if (ch == FRTC_CH_FLASH) begin : g_flash
      assign rise_cycles[ch] = frtc_cycles(FRTC_FLASH_RAMP_NS[rise_code[ch]], CLOCK_PERIOD_NS);
      assign fall_cycles[ch] = frtc_cycles(FRTC_FLASH_RAMP_NS[fall_code[ch]], CLOCK_PERIOD_NS);
    end else begin : g_torch
      assign rise_cycles[ch] = frtc_cycles(FRTC_TORCH_RAMP_NS[rise_code[ch]], CLOCK_PERIOD_NS);
      assign fall_cycles[ch] = frtc_cycles(FRTC_TORCH_RAMP_NS[fall_code[ch]], CLOCK_PERIOD_NS);
    end
  end

  // ==========================================================
  // Registers, current cap and ramp sequencing
  always_comb begin
    logic [FRTC_CHANNELS-1:0] request;
    logic [5:0] cap;
    request = {i_torch_request, flash_timer_enable};
    cap = second_tx_flash_current_cap;
    state_next = state_reg;

    if (i_reg_write) begin
      unique case (i_reg_addr)
        FRTC_ADDR_SECOND_TRANSMIT_LIMIT: begin
          state_next.second_transmit_limit_reg = i_reg_wdata;
        end
        FRTC_ADDR_FLASH_RAMP_RATES: begin
          state_next.flash_ramp_rates_reg = i_reg_wdata & FRTC_RAMP_WRITABLE_MASK;
        end
        FRTC_ADDR_TORCH_RAMP_RATES: begin
          state_next.torch_ramp_rates_reg = i_reg_wdata & FRTC_RAMP_WRITABLE_MASK;
        end
        FRTC_ADDR_FLASH_SAFETY_TIMER: begin
          state_next.flash_safety_timer_reg = i_reg_wdata;
        end
        default: begin
        end
      endcase
    end

    if (i_reg_read) begin
      unique case (i_reg_addr)
        FRTC_ADDR_SECOND_TRANSMIT_LIMIT: begin
          state_next.rdata = state_reg.second_transmit_limit_reg;
        end
        FRTC_ADDR_FLASH_RAMP_RATES: begin
          state_next.rdata = state_reg.flash_ramp_rates_reg;
        end
        FRTC_ADDR_TORCH_RAMP_RATES: begin
          state_next.rdata = state_reg.torch_ramp_rates_reg;
        end
        FRTC_ADDR_FLASH_SAFETY_TIMER: begin
          state_next.rdata = state_reg.flash_safety_timer_reg;
        end
        default: begin
          state_next.rdata = FRTC_UNMAPPED_READ;
        end
      endcase
    end

    if (second_tx_limit_enable && i_second_transmit_event_input
        && (i_flash_current_request > cap)) begin
      state_next.current_code = cap;
    end else begin
      state_next.current_code = i_flash_current_request;
    end

    for (int ch = 0; ch < FRTC_CHANNELS; ch++) begin
      unique case (state_reg.phase[ch])
        FRTC_RAMP_IDLE: begin
          if (request[ch]) begin
            state_next.phase[ch] = FRTC_RAMP_RISE;
            state_next.count[ch] = rise_cycles[ch];
          end
        end
        FRTC_RAMP_RISE: begin
          if (!request[ch]) begin
            state_next.phase[ch] = FRTC_RAMP_FALL;
            state_next.count[ch] = fall_cycles[ch];
          end else if (state_reg.count[ch] <= 1) begin
            state_next.phase[ch] = FRTC_RAMP_HOLD;
          end else begin
            state_next.count[ch] = state_reg.count[ch] - 1'b1;
          end
        end
        FRTC_RAMP_HOLD: begin
          if (!request[ch]) begin
            state_next.phase[ch] = FRTC_RAMP_FALL;
            state_next.count[ch] = fall_cycles[ch];
          end
        end
        FRTC_RAMP_FALL: begin
          if (request[ch]) begin
            state_next.phase[ch] = FRTC_RAMP_RISE;
            state_next.count[ch] = rise_cycles[ch];
          end else if (state_reg.count[ch] <= 1) begin
            state_next.phase[ch] = FRTC_RAMP_IDLE;
          end else begin
            state_next.count[ch] = state_reg.count[ch] - 1'b1;
          end
        end
      endcase
    end

    if (i_logic_supply_undervoltage) begin
      state_next = FRTC_STATE_RESET;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= FRTC_STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign o_reg_rdata = state_reg.rdata;
  assign o_second_tx_input_pulldown = second_tx_input_pulldown;
  assign o_flash_current_code = state_reg.current_code;
  assign o_flash_enable = flash_timer_enable;
  assign o_flash_ramp_phase = state_reg.phase[FRTC_CH_FLASH];
  assign o_torch_ramp_phase = state_reg.phase[FRTC_CH_TORCH];

endmodule

// ==== sim/frtc_checker.sv ====
`timescale 1ns/1ps
// ==========
// Port checker.
module frtc_checker import frtc_pkg::*; #(
  parameter int CLOCK_PERIOD_NS = FRTC_CLOCK_PERIOD_NS
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_logic_supply_undervoltage,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic i_second_transmit_event_input,
  input wire logic [5:0] i_flash_current_request,
  input wire logic i_flash_trigger,
  input wire logic i_torch_request,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_second_tx_input_pulldown,
  input wire logic [5:0] o_flash_current_code,
  input wire logic o_flash_enable,
  input wire logic [1:0] o_flash_ramp_phase,
  input wire logic [1:0] o_torch_ramp_phase
);
  logic [7:0] m [4];
  logic [1:0] idx;
  logic hit;
  logic uv;
  logic [7:0] rd_exp;
  logic [5:0] cap;
  assign uv = i_logic_supply_undervoltage;
  assign idx = 2'(i_reg_addr - 8'h0a);
  assign hit = i_reg_addr >= 8'h0a && i_reg_addr <= 8'h0d;
  assign rd_exp = hit ? m[idx] : 8'h00;
  assign cap = (m[0][7] && i_second_transmit_event_input && i_flash_current_request > m[0][5:0]) ? m[0][5:0]
    : i_flash_current_request;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      m <= '{8'hc0, 8'h00, 8'h00, 8'h00};
    end else if (uv) begin
      m <= '{8'hc0, 8'h00, 8'h00, 8'h00};
    end else if (i_reg_write && hit) begin
      m[idx] <= i_reg_wdata & ((idx[0] ^ idx[1]) ? 8'h77 : 8'hff);
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_burst;
    o_flash_enable [*6] ##1 !o_flash_enable;
  endsequence
  sequence s_shot;
    !m[3][7] && !uv && !o_flash_enable && $rose(i_flash_trigger);
  endsequence
  property p_pulldown;
    i_reg_write && !uv && i_reg_addr == 8'h0a |=> o_second_tx_input_pulldown == $past(i_reg_wdata[6]);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pulldown mismatch");
  property p_cap;
    !uv |=> o_flash_current_code == $past(cap);
  endproperty
  a_cap: assert property (p_cap) else $error("current code mismatch");
  property p_read;
    i_reg_read && !uv |=> o_reg_rdata == $past(rd_exp);
  endproperty
  a_read: assert property (p_read) else $error("read data mismatch");
  property p_uv;
    uv |=> o_reg_rdata == 8'h00 && o_second_tx_input_pulldown && !o_flash_enable && o_flash_ramp_phase == 2'b00;
  endproperty
  a_uv: assert property (p_uv) else $error("defaults not restored");
  property p_start;
    s_shot |=> o_flash_enable;
  endproperty
  a_start: assert property (p_start) else $error("one-shot did not start");
  property p_len;
    CLOCK_PERIOD_NS == 20000 && m[3] == 8'h00 && $rose(o_flash_enable) |-> s_burst;
  endproperty
  a_len: assert property (p_len) else $error("flash length wrong");
  property p_max_drop;
    m[3][7] && !i_flash_trigger |=> !o_flash_enable;
  endproperty
  a_max_drop: assert property (p_max_drop) else $error("flash not released");
  property p_torch;
    i_torch_request && !uv && o_torch_ramp_phase == 2'b00 |=> o_torch_ramp_phase == 2'b01;
  endproperty
  a_torch: assert property (p_torch) else $error("torch rise not entered");
endmodule
bind frtc_top frtc_checker #(.CLOCK_PERIOD_NS(CLOCK_PERIOD_NS)) i_frtc_checker (.i_clock(i_clock),
  .i_reset_n(i_reset_n), .i_logic_supply_undervoltage(i_logic_supply_undervoltage), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
  .i_second_transmit_event_input(i_second_transmit_event_input), .i_flash_current_request(i_flash_current_request),
  .i_flash_trigger(i_flash_trigger), .i_torch_request(i_torch_request), .o_reg_rdata(o_reg_rdata),
  .o_second_tx_input_pulldown(o_second_tx_input_pulldown), .o_flash_current_code(o_flash_current_code),
  .o_flash_enable(o_flash_enable), .o_flash_ramp_phase(o_flash_ramp_phase), .o_torch_ramp_phase(o_torch_ramp_phase));

// ==== sim/frtc_top_test.sv ====
`timescale 1ns/1ps
// ==========
// Register and timing test.
module frtc_top_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic uv = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ev = 1'b0;
  logic trig = 1'b0;
  logic torch = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [5:0] req = 6'h00;
  logic [7:0] rdata;
  logic pd;
  logic [5:0] code;
  logic fen;
  logic [1:0] fph;
  logic [1:0] tph;
  int n_errors = 0;
  int checks = 0;
  int n;
  logic [7:0] tc [3] = '{8'h00, 8'h01, 8'h04};
  int te [3] = '{6, 19, 70};
  always #10 clk = ~clk;
  frtc_top #(.CLOCK_PERIOD_NS(20000)) i_frtc_top (.i_clock(clk), .i_reset_n(rst_n),
    .i_logic_supply_undervoltage(uv), .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_write(wr), .i_reg_read(rd),
    .i_second_transmit_event_input(ev), .i_flash_current_request(req), .i_flash_trigger(trig),
    .i_torch_request(torch), .o_reg_rdata(rdata), .o_second_tx_input_pulldown(pd), .o_flash_current_code(code),
    .o_flash_enable(fen), .o_flash_ramp_phase(fph), .o_torch_ramp_phase(tph));
  task finish_test;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check("rdata", rdata, exp);
    @(negedge clk);
  endtask
  task cap(input logic e, input logic [5:0] r, input logic [5:0] exp);
    ev = e;
    req = r;
    @(negedge clk);
    check("current", code, exp);
  endtask
  function automatic logic [1:0] sel(input int w);
    return w == 0 ? {1'b0, fen} : (w == 1 ? fph : tph);
  endfunction
  task span(input int w, input logic [1:0] ph);
    int k;
    n = 0;
    for (k = 0; k < 40000 && sel(w) !== ph; k++) begin
      @(negedge clk);
    end
    if (k == 40000) begin
      n_errors++;
      finish_test();
    end else begin
      while (sel(w) === ph && n < 40000) begin
        n++;
        @(negedge clk);
      end
    end
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    for (int i = 0; i < 5; i++) begin
      rd_chk(8'(8'h0a + i), i == 0 ? 8'hc0 : 8'h00);
    end
    check("pulldown", pd, 1'b1);
    wr_reg(8'h0b, 8'hff);
    wr_reg(8'h0c, 8'hfb);
    rd_chk(8'h0b, 8'h77);
    rd_chk(8'h0c, 8'h73);
    wr_reg(8'h0a, 8'h90);
    check("pulldown", pd, 1'b0);
    cap(1'b1, 6'h20, 6'h10);
    cap(1'b1, 6'h08, 6'h08);
    cap(1'b0, 6'h20, 6'h20);
    wr_reg(8'h0a, 8'h05);
    cap(1'b1, 6'h3f, 6'h3f);
    wr_reg(8'h0b, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'h0d, tc[i]);
      trig = 1'b1;
      span(0, 2'b01);
      check("flash_on", n, te[i]);
      trig = 1'b0;
      repeat (60) @(negedge clk);
    end
    wr_reg(8'h0b, 8'h50);
    wr_reg(8'h0d, 8'h7f);
    trig = 1'b1;
    span(1, 2'b01);
    check("flash_rise", n, 416);
    span(1, 2'b11);
    check("flash_fall", n, 19);
    trig = 1'b0;
    wr_reg(8'h0c, 8'h01);
    torch = 1'b1;
    span(2, 2'b01);
    check("torch_rise", n, 819);
    torch = 1'b0;
    span(2, 2'b11);
    check("torch_fall", n, 1638);
    wr_reg(8'h0d, 8'h81);
    trig = 1'b1;
    span(0, 2'b01);
    check("max_on", n, 19);
    repeat (5) @(negedge clk);
    check("max_hold_off", fen, 1'b0);
    trig = 1'b0;
    repeat (3) @(negedge clk);
    trig = 1'b1;
    repeat (4) @(negedge clk);
    check("max_follow", fen, 1'b1);
    trig = 1'b0;
    @(negedge clk);
    check("max_release", fen, 1'b0);
    uv = 1'b1;
    addr = 8'h0b;
    wd = 8'h77;
    wr = 1'b1;
    @(negedge clk);
    uv = 1'b0;
    wr = 1'b0;
    @(negedge clk);
    check("uv_pulldown", pd, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'(8'h0a + i), i == 0 ? 8'hc0 : 8'h00);
    end
    finish_test();
  end
endmodule
